// >>> bench/pea_pulse_src.sv
`timescale 1ns/10ps

// ***************************************************************
// Level source on the shared pin
// ***************************************************************
module pea_pulse_src (
  // Clock
  input wire logic sys_clk,
  // Commands from the bench
  input wire logic load,
  input wire logic lvl,
  input wire logic go,
  input wire logic [3:0] n_toggle,
  // Pin side
  output logic pin,
  output logic busy
);
  logic [3:0] left_q;
  logic [1:0] gap_q;

  // Known levels from time zero; the pin is never released
  initial
  begin
    pin = 1'b1;
    left_q = 4'h0;
    gap_q = 2'h0;
  end

  // pin always driven
  // Toggles every 4 cycles so each level outlasts the two-flop sampler
  always @(posedge sys_clk)
  begin
    if (load)
      pin <= lvl;
    if (go)
      left_q <= n_toggle;
    else if (left_q != 4'h0)
    begin
      gap_q <= gap_q + 2'h1;
      if (gap_q == 2'h3)
      begin
        pin <= ~pin;
        left_q <= left_q - 4'h1;
      end
    end
  end

  assign busy = (left_q != 4'h0);
endmodule : pea_pulse_src

// >>> bench/pea_top_tb.sv
`timescale 1ns/10ps
`include "pea_cfg.svh"

module pea_top_tb;
  // Bus, pin and bench state
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:2] wb_adr = 6'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic irq;
  logic pin;
  logic busy;
  logic load = 1'b0;
  logic lvl = 1'b1;
  logic go = 1'b0;
  logic [3:0] n_tog = 4'h0;
  int n_mismatch = 0;
  int checks = 0;
  int seed = 85;
  int i;
  logic [7:0] expq[$];
  logic [7:0] maskq[$];
  logic [7:0] rv;
  logic [7:0] a;

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  pea_top u_pea_top (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .shared_port_pin_seven(pin),
    .irq(irq)
  );

  pea_pulse_src u_pea_pulse_src (
    .sys_clk(sys_clk),
    .load(load),
    .lvl(lvl),
    .go(go),
    .n_toggle(n_tog),
    .pin(pin),
    .busy(busy)
  );

  // ***************************************************************
  // Read answers checked against the oldest note
  // ***************************************************************
  always @(posedge sys_clk)
  begin
    if (wb_ack_o === 1'b1 && wb_we === 1'b0 && expq.size() > 0)
    begin
      checks++;
      if (((wb_dat_o[7:0] ^ expq[0]) & maskq[0]) !== 8'h00 || wb_dat_o[31:8] !== 24'h0)
      begin
        $display("Error %0t: read data %h, expected %h", $time, wb_dat_o, expq[0]);
        n_mismatch++;
      end
      void'(expq.pop_front());
      void'(maskq.pop_front());
    end
  end

  // One classic cycle, held until ack is sampled, then one idle cycle
  task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] d);
    int t;
    begin
      t = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= idx;
      wb_sel <= 4'h1;
      wb_dat <= {24'h0, d};
      do
      begin
        @(posedge sys_clk);
        t++;
      end
      while (wb_ack_o !== 1'b1 && t < 50);
      if (t >= 50)
        n_mismatch++;
      rv = wb_dat_o[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask : wr

  // Bits outside the mask are not compared
  task automatic rd(input logic [5:0] idx, input logic [7:0] e, input logic [7:0] m);
    begin
      expq.push_back(e);
      maskq.push_back(m);
      bus(idx, 1'b0, 8'h00);
    end
  endtask : rd

  // Toggle the pin k times, then allow the three-edge sampling delay
  task automatic tg(input logic [3:0] k);
    begin
      n_tog <= k;
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      @(posedge sys_clk);
      for (i = 0; i < 100 && busy; i++)
        @(posedge sys_clk);
      repeat (6) @(posedge sys_clk);
    end
  endtask : tg

  task automatic chk_irq(input logic e);
    begin
      repeat (2) @(posedge sys_clk);
      checks++;
      if (irq !== e)
      begin
        $display("Error %0t: irq level", $time);
        n_mismatch++;
      end
    end
  endtask : chk_irq

  // Counts gained over 643 cycles; phase of the divide-by-64 is unknown
  task automatic gate(input logic l, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] d;
    begin
      lvl <= l;
      load <= 1'b1;
      @(posedge sys_clk);
      load <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rd(`PEA_IDX_COUNT, 8'h00, 8'h00);
      a = rv;
      repeat (640) @(posedge sys_clk);
      rd(`PEA_IDX_COUNT, 8'h00, 8'h00);
      d = rv - a;
      checks++;
      if ((d >= lo && d <= hi) !== 1'b1)
      begin
        $display("Error %0t: gated count gain %0d", $time, d);
        n_mismatch++;
      end
    end
  endtask : gate

  task automatic end_of_test;
    begin
      $display("Mismatches %0d, checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask : end_of_test

  // Watchdog, well beyond the few thousand cycles needed
  initial
  begin
    #(8 * 20000);
    n_mismatch++;
    end_of_test();
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(`PEA_IDX_CTRL, 8'h00, 8'hFF);
    rd(`PEA_IDX_FLAGS, 8'h00, 8'hFF);
    rd(`PEA_IDX_MASKS, 8'h00, 8'hFF);
    wr(6'h10, 8'hFF);
    rd(6'h10, 8'h00, 8'hFF);
    for (int j = 0; j < 8; j++)
    begin
      a = 8'($random(seed));
      wr(`PEA_IDX_COUNT, a);
      rd(`PEA_IDX_COUNT, a, 8'hFF);
    end
    wr(`PEA_IDX_COUNT, 8'hA5);
    nrst <= 1'b0;
    @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    rd(`PEA_IDX_COUNT, 8'hA5, 8'hFF);
    // Disabled: pin activity leaves everything alone
    wr(`PEA_IDX_COUNT, 8'h00);
    tg(4'h4);
    rd(`PEA_IDX_COUNT, 8'h00, 8'hFF);
    rd(`PEA_IDX_FLAGS, 8'h00, 8'hFF);
    // Event mode, falling edges from a high idle pin
    wr(`PEA_IDX_CTRL, 8'h40);
    tg(4'h4);
    rd(`PEA_IDX_COUNT, 8'h02, 8'hFF);
    rd(`PEA_IDX_FLAGS, 8'h10, 8'hFF);
    wr(`PEA_IDX_FLAGS, 8'h10);
    rd(`PEA_IDX_FLAGS, 8'h00, 8'hFF);
    // Rising polarity: a fall alone does nothing
    wr(`PEA_IDX_CTRL, 8'h50);
    tg(4'h1);
    rd(`PEA_IDX_COUNT, 8'h02, 8'hFF);
    rd(`PEA_IDX_FLAGS, 8'h00, 8'hFF);
    tg(4'h1);
    rd(`PEA_IDX_COUNT, 8'h03, 8'hFF);
    // Wrap from all ones, both flags, selective clears
    wr(`PEA_IDX_FLAGS, 8'h10);
    wr(`PEA_IDX_COUNT, 8'hFF);
    tg(4'h2);
    rd(`PEA_IDX_COUNT, 8'h00, 8'hFF);
    rd(`PEA_IDX_FLAGS, 8'h30, 8'hFF);
    chk_irq(1'b0);
    wr(`PEA_IDX_MASKS, 8'h20);
    chk_irq(1'b1);
    wr(`PEA_IDX_FLAGS, 8'h00);
    rd(`PEA_IDX_FLAGS, 8'h30, 8'hFF);
    wr(`PEA_IDX_FLAGS, 8'h10);
    rd(`PEA_IDX_FLAGS, 8'h20, 8'hFF);
    wr(`PEA_IDX_FLAGS, 8'h20);
    rd(`PEA_IDX_FLAGS, 8'h00, 8'hFF);
    chk_irq(1'b0);
    wr(`PEA_IDX_MASKS, 8'h10);
    tg(4'h2);
    chk_irq(1'b1);
    wr(`PEA_IDX_MASKS, 8'h00);
    chk_irq(1'b0);
    rd(`PEA_IDX_FLAGS, 8'h10, 8'hFF);
    // Gated mode, both inhibit levels
    wr(`PEA_IDX_CTRL, 8'h60);
    gate(1'b1, 8'd10, 8'd11);
    gate(1'b0, 8'd0, 8'd0);
    wr(`PEA_IDX_CTRL, 8'h70);
    gate(1'b0, 8'd10, 8'd11);
    gate(1'b1, 8'd0, 8'd0);
    end_of_test();
  end
endmodule : pea_top_tb

// >>> inc/pea_cfg.svh
`ifndef PEA_CFG_SVH
`define PEA_CFG_SVH

// ***************************************************************
// Register indices (byte address is four times the index)
// ***************************************************************
`define PEA_IDX_MASKS 6'h24
`define PEA_IDX_FLAGS 6'h25
`define PEA_IDX_CTRL 6'h26
`define PEA_IDX_COUNT 6'h27

// ***************************************************************
// Field positions
// ***************************************************************
`define PEA_BIT_WRAP 5
`define PEA_BIT_EDGE 4
`define PEA_BIT_ENABLE 6
`define PEA_BIT_MODE 5
`define PEA_BIT_POLARITY 4

// ***************************************************************
// Reset values and timing counts
// ***************************************************************
`define PEA_CTRL_RESET 1'b0
`define PEA_FLAG_RESET 1'b0
`define PEA_MASK_RESET 1'b0
`define PEA_GATE_DIV 64
`define PEA_DIV_WIDTH 6
`define PEA_DIV_LAST 6'h3F

`endif

// >>> inc/pea_pkg.sv
`include "pea_cfg.svh"

package pea_pkg;

  // Operating modes of the accumulator
  typedef enum logic {PEA_MODE_EVENT, PEA_MODE_GATED} pea_mode_type;

  // State of the top level
  typedef struct packed {
    logic enable;
    pea_mode_type mode;
    logic polarity;
    logic wrap_mask;
    logic edge_mask;
    logic wrap_flag;
    logic edge_flag;
    logic count_seen;
    logic ack;
    logic [31:0] rdata;
  } pea_top_state_type;

  // State of the pin sampler
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [1:0] fill;
  } pea_edge_state_type;

  // State of the gate-time divider
  typedef struct packed {
    logic [`PEA_DIV_WIDTH-1:0] div;
    logic tick;
  } pea_div_state_type;

endpackage : pea_pkg

// >>> src/pea_edge_detect.sv
`timescale 1ns/10ps

module pea_edge_detect (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Pin side
  input wire logic pin_in,
  // Sampled level and edges
  output logic level,
  output logic rise,
  output logic fall
);
  import pea_pkg::*;

  pea_edge_state_type r_q;
  pea_edge_state_type r_d;

  // Sample chain; first stage only feeds the second
  always_comb
  begin
    r_d = r_q;
    r_d.sync1 = pin_in;
    r_d.sync2 = r_q.sync1;
    r_d.prev = r_q.sync2;
    r_d.fill = (r_q.fill == 2'h3) ? 2'h3 : r_q.fill + 2'h1;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  // one event per transition
  // Successive settled samples compared, so each edge lasts one cycle
  assign level = r_q.sync2;
  // Edges held off until the chain holds real samples, so the reset value
  // cannot pose as a transition; a pin change in that short window is lost
  assign rise = r_q.sync2 & ~r_q.prev & (r_q.fill == 2'h3);
  assign fall = ~r_q.sync2 & r_q.prev & (r_q.fill == 2'h3);

  AST_EDGE_ONE_CYCLE:
  assert property (@(posedge sys_clk) disable iff (!nrst) (rise || fall) |=> !(rise || fall))
  else $error("edge pulse lasted more than one cycle");

endmodule : pea_edge_detect

// >>> src/pea_gate_divider.sv
`timescale 1ns/10ps
`include "pea_cfg.svh"

module pea_gate_divider (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // One-cycle tick every divider period
  output logic tick
);
  import pea_pkg::*;

  pea_div_state_type r_q;
  pea_div_state_type r_d;

  // Free-running divider; never gated so the time base stays steady
  always_comb
  begin
    r_d = r_q;
    r_d.div = r_q.div + `PEA_DIV_WIDTH'(1);
    r_d.tick = (r_q.div == `PEA_DIV_LAST);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign tick = r_q.tick;

  AST_TICK_PERIOD:
  assert property (@(posedge sys_clk) disable iff (!nrst) tick |=> !tick [*8])
  else $error("divider tick repeated too early");

endmodule : pea_gate_divider

// >>> src/pea_top.sv
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "pea_cfg.svh"

module pea_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pulse input pin level
  input wire logic shared_port_pin_seven,
  // Interrupt
  output logic irq
);
  import pea_pkg::*;

  // ***************************************************************
  // Helpers
  // ***************************************************************

  // Register index match
  function automatic logic reg_hit(input logic [5:0] adr, input logic [5:0] idx);
    reg_hit = (adr == idx);
  endfunction : reg_hit

  // ***************************************************************
  // Declarations
  // ***************************************************************

  pea_top_state_type r_q;
  pea_top_state_type r_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic gate_tick;
  logic sel_edge;
  logic gate_open;
  logic count_inc;
  logic bus_req;
  logic bus_wr;
  logic count_wr;
  logic flags_wr;
  logic ctrl_wr;
  logic masks_wr;
  logic wrap_set;
  logic edge_set;
  logic wrap_clr;
  logic edge_clr;
  logic [7:0] rd_byte;

  // ***************************************************************
  // Pin sampling and time base
  // ***************************************************************

  // pin level fed regardless of direction
  // The pad level is taken whatever drives the pin
  pea_edge_detect u_edge (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .pin_in(shared_port_pin_seven),
    .level(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  pea_gate_divider u_div (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .tick(gate_tick)
  );

  // ***************************************************************
  // Counting
  // ***************************************************************

  assign sel_edge = r_q.polarity ? pin_rise : pin_fall;

  // inhibit level is the polarity bit itself
  assign gate_open = (pin_level != r_q.polarity);

  // mode selects edge or gated time source
  always_comb
  begin
    count_inc = 1'b0;
    if (r_q.enable)
    begin
      unique case (r_q.mode)
        PEA_MODE_EVENT: count_inc = sel_edge;
        PEA_MODE_GATED: count_inc = gate_tick && gate_open;
      endcase
    end
  end

  // ***************************************************************
  // Bus decode
  // ***************************************************************

  // Ack one cycle after the request; writes land on the ack edge
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0] && r_q.ack;
  assign count_wr = bus_wr && reg_hit(wb_adr_i, `PEA_IDX_COUNT);
  assign flags_wr = bus_wr && reg_hit(wb_adr_i, `PEA_IDX_FLAGS);
  assign ctrl_wr = bus_wr && reg_hit(wb_adr_i, `PEA_IDX_CTRL);
  assign masks_wr = bus_wr && reg_hit(wb_adr_i, `PEA_IDX_MASKS);

  // Read mux; unmapped and unused bits read zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (reg_hit(wb_adr_i, `PEA_IDX_COUNT))
      rd_byte = count_q;
    else if (reg_hit(wb_adr_i, `PEA_IDX_FLAGS))
    begin
      rd_byte[`PEA_BIT_WRAP] = r_q.wrap_flag;
      rd_byte[`PEA_BIT_EDGE] = r_q.edge_flag;
    end
    else if (reg_hit(wb_adr_i, `PEA_IDX_MASKS))
    begin
      rd_byte[`PEA_BIT_WRAP] = r_q.wrap_mask;
      rd_byte[`PEA_BIT_EDGE] = r_q.edge_mask;
    end
    else if (reg_hit(wb_adr_i, `PEA_IDX_CTRL))
    begin
      rd_byte[`PEA_BIT_ENABLE] = r_q.enable;
      rd_byte[`PEA_BIT_MODE] = r_q.mode;
      rd_byte[`PEA_BIT_POLARITY] = r_q.polarity;
    end
  end

  // ***************************************************************
  // Flags
  // ***************************************************************

  // wrap on all-ones increment; a same-edge software write wins
  assign wrap_set = count_inc && (count_q == 8'hFF) && !count_wr;

  // selected edge sets the flag while the accumulator runs
  assign edge_set = r_q.enable && sel_edge;

  // only bits written with one clear
  assign wrap_clr = flags_wr && wb_dat_i[`PEA_BIT_WRAP];
  assign edge_clr = flags_wr && wb_dat_i[`PEA_BIT_EDGE];

  // ***************************************************************
  // Next state
  // ***************************************************************

  // Control, masks, sticky flags and bus answer
  always_comb
  begin
    r_d = r_q;
    r_d.ack = bus_req && !r_q.ack;
    if (bus_req && !r_q.ack)
      r_d.rdata = {24'h000000, rd_byte};
    if (ctrl_wr)
    begin
      r_d.enable = wb_dat_i[`PEA_BIT_ENABLE];
      r_d.mode = pea_mode_type'(wb_dat_i[`PEA_BIT_MODE]);
      r_d.polarity = wb_dat_i[`PEA_BIT_POLARITY];
    end
    if (masks_wr)
    begin
      r_d.wrap_mask = wb_dat_i[`PEA_BIT_WRAP];
      r_d.edge_mask = wb_dat_i[`PEA_BIT_EDGE];
    end
    // Set beats a clear arriving on the same edge
    r_d.wrap_flag = wrap_set || (r_q.wrap_flag && !wrap_clr);
    r_d.edge_flag = edge_set || (r_q.edge_flag && !edge_clr);
    // Check helper: count holds a written value, so checks on it are meaningful
    r_d.count_seen = r_q.count_seen || count_wr;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      r_q <= '0;
      r_q.enable <= `PEA_CTRL_RESET;
      r_q.wrap_flag <= `PEA_FLAG_RESET;
      r_q.edge_flag <= `PEA_FLAG_RESET;
      r_q.wrap_mask <= `PEA_MASK_RESET;
      r_q.edge_mask <= `PEA_MASK_RESET;
    end
    else
      r_q <= r_d;
  end

  // ***************************************************************
  // Count register
  // ***************************************************************

  // single-edge update, so a read captures a whole count
  always_comb
  begin
    count_d = count_q;
    if (count_wr)
      count_d = wb_dat_i[7:0];
    else if (count_inc)
      count_d = count_q + 8'h01;
  end

  // no reset on the count
  // Kept out of the reset struct on purpose: power-up value is undefined
  always_ff @(posedge sys_clk)
  begin
    count_q <= count_d;
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************

  assign wb_ack_o = r_q.ack;
  assign wb_dat_o = r_q.rdata;

  // wrap interrupt gated by its enable
  // edge interrupt gated by its enable
  assign irq = (r_q.wrap_flag && r_q.wrap_mask) || (r_q.edge_flag && r_q.edge_mask);

  // ***************************************************************
  // Checks
  // ***************************************************************

  AST_EVENT_FALL_COUNTS:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.count_seen && r_q.enable && r_q.mode == PEA_MODE_EVENT && !r_q.polarity
     && pin_fall && !count_wr)
    |=> count_q == $past(count_q) + 8'h01)
  else $error("falling edge did not advance count");

  // rising edge ignored with polarity 0
  AST_EVENT_RISE_IGNORED:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.count_seen && r_q.mode == PEA_MODE_EVENT && !r_q.polarity && pin_rise && !count_wr)
    |=> $stable(count_q))
  else $error("wrong edge advanced count");

  AST_GATE_INHIBIT:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.count_seen && r_q.mode == PEA_MODE_GATED && pin_level == r_q.polarity && !count_wr)
    |=> $stable(count_q))
  else $error("count moved while gate inhibited");

  AST_GATE_TICK_COUNTS:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.enable && r_q.mode == PEA_MODE_GATED && gate_tick && pin_level != r_q.polarity
     && r_q.count_seen && !count_wr) |=> count_q == $past(count_q) + 8'h01)
  else $error("gated tick did not advance count");

  AST_DISABLED_HOLDS:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.count_seen && !r_q.enable && !count_wr) |=> $stable(count_q))
  else $error("count moved while disabled");

  AST_COUNT_WRITE:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    count_wr |=> count_q == $past(wb_dat_i[7:0]))
  else $error("count write lost");

  AST_WRAP_FLAG_SET:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (count_inc && count_q == 8'hFF && !count_wr) |=> (r_q.wrap_flag && count_q == 8'h00))
  else $error("roll-over did not set wrap flag");

  AST_WRAP_FLAG_CLEAR:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (wrap_clr && !wrap_set) |=> !r_q.wrap_flag)
  else $error("wrap flag not cleared by write of one");

  AST_EDGE_FLAG_KEEP:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (flags_wr && !wb_dat_i[`PEA_BIT_EDGE] && r_q.edge_flag) |=> r_q.edge_flag)
  else $error("edge flag cleared by write of zero");

  AST_EDGE_FLAG_SET:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.enable && sel_edge) |=> r_q.edge_flag)
  else $error("selected edge did not set edge flag");

  // enabled wrap flag always raises the request
  AST_WRAP_IRQ:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (r_q.wrap_flag && r_q.wrap_mask) |-> irq)
  else $error("wrap interrupt missing");

  AST_IRQ_QUIET:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (!r_q.wrap_mask && !r_q.edge_mask) |-> !irq)
  else $error("interrupt raised with enables clear");

  AST_WRAP_FLAG_KEEP:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (flags_wr && !wb_dat_i[`PEA_BIT_WRAP] && r_q.wrap_flag) |=> r_q.wrap_flag)
  else $error("wrap flag cleared by write of zero");

  AST_EDGE_FLAG_CLEAR:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (edge_clr && !edge_set) |=> !r_q.edge_flag)
  else $error("edge flag not cleared by write of one");

  // enable write leaves the flags alone
  AST_MASK_KEEPS_FLAGS:
  assert property (@(posedge sys_clk) disable iff (!nrst)
    (masks_wr && !edge_set && !wrap_set)
    |=> (r_q.edge_flag == $past(r_q.edge_flag) && r_q.wrap_flag == $past(r_q.wrap_flag)))
  else $error("enable write altered a flag");

  AST_ACK_ONE_CYCLE:
  assert property (@(posedge sys_clk) disable iff (!nrst) wb_ack_o |=> !wb_ack_o)
  else $error("bus answer lasted more than one cycle");

endmodule : pea_top
